// ### hrr_pkg.sv
/*
  Shared constants and carrier types for the hardware-information and
  previous-shadow-set register read unit.
  Assumes a 32-bit core with 32 general registers and a pipeline on the same clock.
*/
// Contract
// - permitted hardware read writes destination general register
// - each hardware register gated by own mask bit
// - source 0 returns processor index
// - source 1 returns icache sync step
// - source 2 returns cycle counter value
// - source 3 returns counter resolution
// - sources 4 to 28 raise reserved-instruction
// - source 29 returns thread pointer if implemented
// - unimplemented sources 30, 31 raise reserved-instruction
// - allowed when cp0 enabled or mask bit set
// - refused or unimplemented: exception, no writeback
// - release one treats hardware read as reserved
// - copy shadow register of previous set to current
// - decode cp0 opcode, sub-op field, zero low bits
// - before release two shadow read is reserved
package hrr_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] HRR_ENA_OFS = 8'h00;
  localparam logic [7:0] HRR_PIDX_OFS = 8'h04;
  localparam logic [7:0] HRR_SRS_OFS = 8'h08;
  localparam logic [7:0] HRR_TLS_OFS = 8'h0c;
  localparam logic [7:0] HRR_COUNT_OFS = 8'h10;
  localparam logic [7:0] HRR_STAT_OFS = 8'h14;
  localparam logic [7:0] HRR_MASK_OFS = 8'h18;
  localparam logic [7:0] HRR_STEP_OFS = 8'h1c;
  // ==========================================================
  // field positions and reset values
  localparam int HRR_CPU_W = 10;
  localparam int HRR_PREV_LSB = 6;
  localparam int HRR_PREV_W = 4;
  localparam int HRR_EV_RI = 0;
  localparam int HRR_EV_HWR = 1;
  localparam int HRR_EV_PGPR = 2;
  localparam int HRR_EV_W = 3;
  localparam logic [31:0] HRR_ZERO_RST = 32'h0;
  // ==========================================================
  // instruction fields and encodings
  localparam logic [5:0] HRR_OPC_COP0 = 6'h10;
  localparam logic [4:0] HRR_SUB_PGPR = 5'h0a;
  localparam logic [10:0] HRR_LOW_ZERO = 11'h000;
  localparam logic [4:0] HRR_SRC_CPU = 5'h00;
  localparam logic [4:0] HRR_SRC_STEP = 5'h01;
  localparam logic [4:0] HRR_SRC_CYC = 5'h02;
  localparam logic [4:0] HRR_SRC_RES = 5'h03;
  localparam logic [4:0] HRR_SRC_TLS = 5'h1d;
  localparam logic [4:0] HRR_SRC_IMP0 = 5'h1e;
  localparam logic [4:0] HRR_SRC_IMP1 = 5'h1f;
  localparam int HRR_REL_PGPR = 2;
  localparam int HRR_REL_HWR = 2;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic is_hwr;
    logic [31:0] word;
  } hrr_instr_t;
  typedef struct packed {
    logic valid;
    logic wr_en;
    logic ri;
    logic [4:0] dest;
    logic [31:0] data;
  } hrr_result_t;
  typedef struct packed {
    logic valid;
    logic [HRR_PREV_W-1:0] set;
    logic [4:0] idx;
  } hrr_sgpr_req_t;
endpackage

// ### hrr_unit.sv
/*
  Hardware-information register read and previous-shadow-set read unit,
  with an AXI4-Lite register slave and a level interrupt.
  Assumes the pipeline holds an instruction until ready, and that the shadow
  register file answers a request with data in the same cycle.
*/
`timescale 1ns/1ps
module hrr_unit #(
  parameter int ARCH_REV = 2,
  parameter logic [31:0] ICACHE_SYNC_STEP = 32'h20,
  parameter int CYC_RES = 1,
  parameter bit TLS_IMPL = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire hrr_pkg::hrr_instr_t instr_in,
  output logic instr_ready,
  input wire logic cp0_enabled,
  output hrr_pkg::hrr_sgpr_req_t sgpr_req,
  input wire logic [31:0] sgpr_data,
  output hrr_pkg::hrr_result_t result,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import hrr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SHADOW, ST_DONE} hrr_state_t;

  localparam logic [31:0] CYC_RES_W = 32'(CYC_RES);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  logic [31:0] ena_mask_r;
  logic [HRR_CPU_W-1:0] cpu_idx_r;
  logic [HRR_PREV_W-1:0] prev_set_r;
  logic [31:0] tls_r;
  logic [31:0] count_r;
  logic [31:0] presc_r;
  logic [HRR_EV_W-1:0] stat_r;
  logic [HRR_EV_W-1:0] stat_nxt;
  logic [HRR_EV_W-1:0] mask_r;
  logic [HRR_EV_W-1:0] mask_nxt;
  logic [HRR_EV_W-1:0] ev;
  hrr_state_t state_r;
  logic [4:0] dest_r;
  logic take;
  logic [4:0] f_tgt;
  logic [4:0] f_rd;
  logic is_pgpr;
  logic hwr_ok;
  logic hwr_impl;
  logic hwr_allow;
  logic [31:0] hwr_val;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic wr_hit;
  logic rd_fire;
  logic [31:0] rd_val;
  logic rd_hit;

  // ==========================================================
  // instruction decode
  assign instr_ready = (state_r == ST_IDLE);
  assign take = instr_in.valid && instr_ready;
  assign f_tgt = instr_in.word[20:16];
  assign f_rd = instr_in.word[15:11];
  assign is_pgpr = !instr_in.is_hwr && (instr_in.word[31:26] == HRR_OPC_COP0)
    && (instr_in.word[25:21] == HRR_SUB_PGPR) && (instr_in.word[10:0] == HRR_LOW_ZERO);

  // 30 and 31 are left unimplemented here
  always_comb begin
    hwr_impl = 1'b1;
    hwr_val = 32'h0;
    unique case (f_rd)
      HRR_SRC_CPU: hwr_val = 32'(cpu_idx_r);
      HRR_SRC_STEP: hwr_val = ICACHE_SYNC_STEP;
      HRR_SRC_CYC: hwr_val = count_r;
      HRR_SRC_RES: hwr_val = CYC_RES_W;
      HRR_SRC_TLS: begin
        hwr_impl = TLS_IMPL;
        hwr_val = tls_r;
      end
      HRR_SRC_IMP0, HRR_SRC_IMP1: hwr_impl = 1'b0;
      default: hwr_impl = 1'b0;
    endcase
  end

  assign hwr_allow = cp0_enabled || ena_mask_r[f_rd];
  assign hwr_ok = hwr_allow && hwr_impl && (ARCH_REV >= HRR_REL_HWR);

  // ==========================================================
  // sequencing: hardware reads answer next cycle, shadow reads in two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      dest_r <= 5'h0;
      sgpr_req <= '0;
    end else begin
      sgpr_req.valid <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (take && is_pgpr && (ARCH_REV >= HRR_REL_PGPR)) begin
            state_r <= ST_SHADOW;
            dest_r <= f_rd;
            sgpr_req.valid <= 1'b1;
            sgpr_req.set <= prev_set_r;
            sgpr_req.idx <= f_tgt;
          end
        end
        ST_SHADOW: state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
    end else begin
      result <= '0;
      if (take && instr_in.is_hwr) begin
        result.valid <= 1'b1;
        result.wr_en <= hwr_ok;
        result.ri <= !hwr_ok;
        result.dest <= f_tgt;
        result.data <= hwr_ok ? hwr_val : 32'h0;
      end else if (take && is_pgpr && (ARCH_REV < HRR_REL_PGPR)) begin
        result.valid <= 1'b1;
        result.ri <= 1'b1;
      end else if (state_r == ST_SHADOW) begin
        result.valid <= 1'b1;
        result.wr_en <= 1'b1;
        result.dest <= dest_r;
        result.data <= sgpr_data;
      end
    end
  end

  // ==========================================================
  // cycle counter, advancing once every CYC_RES cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= HRR_ZERO_RST;
      presc_r <= HRR_ZERO_RST;
    end else if (wr_fire && aw_addr_r == HRR_COUNT_OFS) begin
      count_r <= w_data_r;
      presc_r <= HRR_ZERO_RST;
    end else if (presc_r >= CYC_RES_W - 32'h1) begin
      count_r <= count_r + 32'h1;
      presc_r <= HRR_ZERO_RST;
    end else begin
      presc_r <= presc_r + 32'h1;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel; address and data taken in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_hit = (aw_addr_r == HRR_ENA_OFS) || (aw_addr_r == HRR_PIDX_OFS)
    || (aw_addr_r == HRR_SRS_OFS) || (aw_addr_r == HRR_TLS_OFS)
    || (aw_addr_r == HRR_COUNT_OFS) || (aw_addr_r == HRR_MASK_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte lanes honoured on the enable mask and thread pointer (the counter takes the whole word); narrow fields take lane 0 and 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena_mask_r <= HRR_ZERO_RST;
      cpu_idx_r <= '0;
      prev_set_r <= '0;
      tls_r <= HRR_ZERO_RST;
      mask_r <= '0;
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_r[b]) begin
          if (aw_addr_r == HRR_ENA_OFS) ena_mask_r[b*8 +: 8] <= w_data_r[b*8 +: 8];
          if (aw_addr_r == HRR_TLS_OFS) tls_r[b*8 +: 8] <= w_data_r[b*8 +: 8];
        end
      end
      if (aw_addr_r == HRR_PIDX_OFS && w_strb_r[0]) cpu_idx_r <= w_data_r[HRR_CPU_W-1:0];
      if (aw_addr_r == HRR_SRS_OFS && w_strb_r[1]) begin
        prev_set_r <= w_data_r[HRR_PREV_LSB +: HRR_PREV_W];
      end
      mask_r <= mask_nxt;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    unique case (s_axi_araddr)
      HRR_ENA_OFS: rd_val = ena_mask_r;
      HRR_PIDX_OFS: rd_val = 32'(cpu_idx_r);
      HRR_SRS_OFS: rd_val = 32'(prev_set_r) << HRR_PREV_LSB;
      HRR_TLS_OFS: rd_val = tls_r;
      HRR_COUNT_OFS: rd_val = count_r;
      HRR_STAT_OFS: rd_val = 32'(stat_r);
      HRR_MASK_OFS: rd_val = 32'(mask_r);
      HRR_STEP_OFS: rd_val = ICACHE_SYNC_STEP;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OK;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt status: read clears, a new event in the same cycle survives
  assign ev[HRR_EV_RI] = result.valid && result.ri;
  assign ev[HRR_EV_HWR] = result.valid && result.wr_en && (state_r != ST_DONE);
  assign ev[HRR_EV_PGPR] = result.valid && (state_r == ST_DONE);

  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (rd_fire && s_axi_araddr == HRR_STAT_OFS) stat_nxt = '0;
    stat_nxt = stat_nxt | ev;
    if (wr_fire && aw_addr_r == HRR_MASK_OFS && w_strb_r[0]) mask_nxt = w_data_r[HRR_EV_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
      irq <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      // next mask, not mask_r: a mask write must not leave irq a cycle behind status
      irq <= |(stat_nxt & mask_nxt);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic hwr_take;
  assign hwr_take = take && instr_in.is_hwr;

  sequence pgpr_issue;
    take && is_pgpr && (ARCH_REV >= 2);
  endsequence
  sequence pgpr_finish;
    sgpr_req.valid && sgpr_req.set == $past(prev_set_r) ##1
      result.valid && result.wr_en && result.data == $past(sgpr_data);
  endsequence

  hwr_write_back_a: assert property (hwr_take && hwr_ok |=>
    result.valid && result.wr_en && result.dest == $past(f_tgt))
    else $error("permitted hardware read not written back");
  cpu_index_a: assert property (hwr_take && hwr_ok && f_rd == 5'h00 |=>
    result.data == 32'($past(cpu_idx_r)))
    else $error("processor index read wrong");
  sync_step_a: assert property (hwr_take && hwr_ok && f_rd == 5'h01 |=>
    result.data == ICACHE_SYNC_STEP)
    else $error("sync step read wrong");
  cycle_count_a: assert property (hwr_take && hwr_ok && f_rd == 5'h02 |=>
    result.data == $past(count_r))
    else $error("cycle counter read wrong");
  count_res_a: assert property (hwr_take && hwr_ok && f_rd == 5'h03 |=>
    result.data == CYC_RES_W)
    else $error("resolution read wrong");
  reserved_src_a: assert property (hwr_take && f_rd >= 5'h04 && f_rd <= 5'h1c |=>
    result.ri && !result.wr_en)
    else $error("reserved source not refused");
  tls_read_a: assert property (hwr_take && hwr_ok && f_rd == 5'h1d |=>
    result.data == $past(tls_r))
    else $error("thread pointer read wrong");
  impl_src_a: assert property (hwr_take && f_rd >= 5'h1e |=> result.ri)
    else $error("unimplemented source not refused");
  mask_gate_a: assert property (hwr_take && !cp0_enabled && !ena_mask_r[f_rd] |=>
    result.valid && result.ri && !result.wr_en)
    else $error("gated read not refused");
  shadow_copy_a: assert property (pgpr_issue |=> pgpr_finish)
    else $error("shadow copy sequence broken");
  decode_reject_a: assert property (take && !instr_in.is_hwr && !is_pgpr |=>
    !result.valid && !sgpr_req.valid)
    else $error("non-matching word acted upon");
  irq_level_a: assert property (irq == |(stat_r & mask_r))
    else $error("interrupt level disagrees with unmasked status");
  ri_no_write_a: assert property (result.valid && result.ri |->
    !result.wr_en && result.data == 32'h0)
    else $error("refused read still writes");
  old_rel_hwr_a: assert property (hwr_take && ARCH_REV < HRR_REL_HWR |=> result.ri)
    else $error("hardware read allowed on release one");
  old_rel_pgpr_a: assert property (take && is_pgpr && ARCH_REV < HRR_REL_PGPR |=>
    result.valid && result.ri && !sgpr_req.valid)
    else $error("shadow read allowed before release two");
endmodule

// ### hrr_sgpr_model.sv
/*
  shadow register file model for the previous-set read port.
  assumes one request pulse per read and answers in the same cycle.
*/
`timescale 1ns/1ps
module hrr_sgpr_model
  import hrr_pkg::*;
(
  input wire logic aclk,
  input wire hrr_pkg::hrr_sgpr_req_t req,
  output logic [31:0] data
);
  // ==========================================
  // answer
  logic [31:0] last_r;
  // idle cycles show the inverse of the last word so a stale sample cannot match
  assign data = req.valid ? {8'h5a, 15'h0, req.set, req.idx} : ~last_r;
  always_ff @(posedge aclk) begin
    last_r <= data;
  end
endmodule

// ### testbench.sv
/*
  self-checking bench for the register read unit.
  assumes one clock, a shadow file model and an AXI4-Lite master here.
*/
`timescale 1ns/1ps
module testbench;
  import hrr_pkg::*;
  localparam logic [31:0] STEP = 32'h40;
  localparam int RES = 3;
  logic aclk = 1'b0;
  logic aresetn;
  logic cp0_enabled;
  logic instr_ready;
  logic irq;
  logic [31:0] sgpr_data;
  hrr_instr_t instr_in;
  hrr_sgpr_req_t sgpr_req;
  hrr_result_t result;
  hrr_sgpr_req_t r1_req;
  hrr_result_t r1_result;
  logic [7:0] s_axi_awaddr;
  logic [7:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int total_checks = 0;
  always #20 aclk = ~aclk;
  // ==========================================
  // design and partner
  hrr_unit #(.ICACHE_SYNC_STEP(STEP), .CYC_RES(RES)) dut (
    .aclk(aclk), .aresetn(aresetn), .instr_in(instr_in), .instr_ready(instr_ready),
    .cp0_enabled(cp0_enabled), .sgpr_req(sgpr_req), .sgpr_data(sgpr_data),
    .result(result), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  // release-one build on the same stimulus: every read it sees must come back reserved
  hrr_unit #(.ARCH_REV(1)) dut_rel1 (
    .aclk(aclk), .aresetn(aresetn), .instr_in(instr_in), .instr_ready(),
    .cp0_enabled(cp0_enabled), .sgpr_req(r1_req), .sgpr_data(sgpr_data),
    .result(r1_result), .irq(), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready)
  );
  hrr_sgpr_model shadow (.aclk(aclk), .req(sgpr_req), .data(sgpr_data));
  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  // source s lands in register 31-s so every source has its own destination
  task automatic hwr(input int s, input logic ri, input logic [31:0] d, input bit dchk);
    logic [4:0] dst;
    @(posedge aclk);
    dst = 5'(31 - s);
    instr_in <= {2'b11, 11'h0, dst, 5'(s), 11'h0};
    @(posedge aclk);
    instr_in <= '0;
    @(posedge aclk);
    chk("hwr flags", {1'b1, !ri, ri}, {result.valid, result.wr_en, result.ri});
    if (!ri) chk("hwr dest", dst, result.dest);
    if (dchk) chk("hwr data", d, result.data);
    chk("rel1 hwr", 3'b101, {r1_result.valid, r1_result.wr_en, r1_result.ri});
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    rd_chk(HRR_STAT_OFS, 32'h0, 2'b00);
    rd_chk(HRR_ENA_OFS, 32'h0, 2'b00);
    rd_chk(HRR_STEP_OFS, STEP, 2'b00);
    rd_chk(8'h40, 32'h0, 2'b10);
    axi_wr(8'h40, 32'h1, 2'b10);
    axi_wr(HRR_PIDX_OFS, 32'h0000_0123);
    axi_wr(HRR_TLS_OFS, 32'hdead_beef);
    axi_wr(HRR_SRS_OFS, 32'h0000_0140);
    rd_chk(HRR_PIDX_OFS, 32'h123, 2'b00);
  endtask
  task automatic t_sources();
    logic [31:0] e;
    axi_wr(HRR_ENA_OFS, 32'hffff_ffff);
    for (int s = 0; s < 32; s++) begin
      case (s)
        0: e = 32'h123;
        1: e = STEP;
        3: e = RES;
        29: e = 32'hdead_beef;
        default: e = 32'h0;
      endcase
      hwr(s, !(s < 4 || s == 29), e, s != 2);
    end
  endtask
  // four back-to-back counter reads span three cycles: exactly one step
  task automatic t_count();
    logic [31:0] c [4];
    @(posedge aclk);
    instr_in <= {2'b11, 11'h0, 5'd2, 5'd2, 11'h0};
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      c[i] = result.data;
      if (i == 2) instr_in <= '0;
    end
    chk("cc step", 32'd1, c[3] - c[0]);
  endtask
  task automatic t_gate();
    for (int k = 0; k < 4; k++) begin
      axi_wr(HRR_ENA_OFS, 32'h1 << k);
      for (int s = 0; s < 4; s++) hwr(s, s != k, 32'h0, s != k);
    end
    axi_wr(HRR_ENA_OFS, 32'h0);
    cp0_enabled <= 1'b1;
    hwr(0, 1'b0, 32'h123, 1'b1);
    hwr(5, 1'b1, 32'h0, 1'b1);
  endtask
  task automatic t_shadow();
    @(posedge aclk);
    instr_in <= {2'b10, HRR_OPC_COP0, HRR_SUB_PGPR, 5'd7, 5'd9, HRR_LOW_ZERO};
    @(posedge aclk);
    instr_in <= '0;
    @(posedge aclk);
    chk("sgpr req", {1'b1, 4'd5, 5'd7}, sgpr_req);
    chk("busy", 1'b0, instr_ready);
    chk("rel1 pgpr", 4'b1010, {r1_result.valid, r1_result.wr_en, r1_result.ri, r1_req.valid});
    @(posedge aclk);
    chk("pgpr", {3'b110, 5'd9, 8'h5a, 15'h0, 4'd5, 5'd7}, result);
    instr_in <= {2'b10, HRR_OPC_COP0, HRR_SUB_PGPR, 5'd7, 5'd9, 11'h001};
    repeat (4) begin
      @(posedge aclk);
      chk("stray", 1'b0, result.valid | sgpr_req.valid);
    end
    instr_in <= '0;
  endtask
  task automatic t_irq();
    chk("irq masked", 1'b0, irq);
    rd_chk(HRR_STAT_OFS, 32'h7, 2'b00);
    axi_wr(HRR_MASK_OFS, 32'h1);
    hwr(30, 1'b1, 32'h0, 1'b1);
    repeat (2) @(posedge aclk);
    chk("irq set", 1'b1, irq);
    rd_chk(HRR_STAT_OFS, 32'h1, 2'b00);
    repeat (2) @(posedge aclk);
    chk("irq clear", 1'b0, irq);
    hwr(0, 1'b0, 32'h123, 1'b1);
    repeat (2) @(posedge aclk);
    chk("irq other", 1'b0, irq);
    axi_wr(HRR_MASK_OFS, 32'h3);
    chk("irq unmask", 1'b1, irq);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    aresetn = 1'b0;
    cp0_enabled = 1'b0;
    instr_in = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_sources();
    t_count();
    t_gate();
    t_shadow();
    t_irq();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    close_out();
  end
endmodule
